// File: inc/pcp_pkg.sv
package pcp_pkg;
  localparam int CNT_W = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MRELOAD = 8'h04;
  localparam logic [7:0] ADDR_SRELOAD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MCOUNT = 8'h10;
  localparam logic [7:0] ADDR_SCOUNT = 8'h14;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_OE = 2;
  localparam int CTRL_MODE = 3;
  localparam int CTRL_LEVEL = 4;
  localparam int STAT_RUN = 0;
  localparam int STAT_PIN = 1;
  localparam int STAT_EVT = 2;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [7:0] PRESCALE_DEF = 8'h01;
endpackage

// File: inc/pcp_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcp_cfg_if;
  logic start;
  logic stop;
  logic [15:0] masterReload;
  logic [15:0] slaveReload;
  logic outEnable;
  logic outLevel;
  logic running;
  logic periodEvent;
  logic pinLevel;
  logic [15:0] masterCount;
  logic [15:0] slaveCount;
  modport ctl (output start, stop, masterReload, slaveReload, outEnable,
    outLevel, input running, periodEvent, pinLevel, masterCount, slaveCount);
  modport core (input start, stop, masterReload, slaveReload, outEnable,
    outLevel, output running, periodEvent, pinLevel, masterCount,
    slaveCount);
endinterface
`default_nettype wire

// File: core/pcp_pair_core.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_pair_core (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic countTick,
  pcp_cfg_if.core cfg
);
  import pcp_pkg::*;

  logic running_reg;
  logic [15:0] mCount_reg;
  logic [15:0] sCount_reg;
  logic sActive_reg;
  logic pin_reg;
  logic evt;
  logic started_reg;

  ////////////////////////////////////////////////////////////////
  // Event on a start while idle and on each master zero reached on a tick
  assign evt = (cfg.start && !running_reg) ||
    (running_reg && countTick && mCount_reg == 16'h0000);

  // Run flag
  always_ff @(posedge clk_sys) begin
    if (reset || cfg.stop) begin
      running_reg <= 1'b0;
    end else if (cfg.start) begin
      running_reg <= 1'b1;
    end
  end

  // Master down-counter, reloads at every event
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mCount_reg <= 16'h0000;
    end else if (evt) begin
      mCount_reg <= cfg.masterReload;
    end else if (running_reg && countTick) begin
      mCount_reg <= mCount_reg - 16'h0001;
    end
  end

  // Slave one-count: loads at event, counts each tick, halts at zero
  // until the next event; sActive marks the first tick after a load
  always_ff @(posedge clk_sys) begin
    if (reset || cfg.stop) begin
      sCount_reg <= 16'h0000;
      sActive_reg <= 1'b0;
      started_reg <= 1'b0;
    end else if (evt) begin
      sCount_reg <= cfg.slaveReload;
      sActive_reg <= 1'b1;
      started_reg <= 1'b1;
    end else if (countTick) begin
      if (sCount_reg != 16'h0000) begin
        sCount_reg <= sCount_reg - 16'h0001;
      end
      sActive_reg <= 1'b0;
    end
  end

  // Pin: set on the first tick after an event if the slave load is nonzero, cleared on the tick that
  // sees the slave count at zero; a reload that outlasts the period is
  // reloaded before it reaches zero, so the pin never drops.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_reg <= 1'b0;
    end else if (!cfg.outEnable) begin
      pin_reg <= pin_reg;
    end else if (!started_reg || !running_reg) begin
      pin_reg <= cfg.outLevel;
    end else if (countTick) begin
      if (sActive_reg) begin
        pin_reg <= (sCount_reg != 16'h0000);
      end else if (sCount_reg == 16'h0000) begin
        pin_reg <= 1'b0;
      end
    end
  end

  assign cfg.running = running_reg;
  assign cfg.periodEvent = evt;
  assign cfg.pinLevel = pin_reg;
  assign cfg.masterCount = mCount_reg;
  assign cfg.slaveCount = sCount_reg;

  a_master_reload: assert property (@(posedge clk_sys) disable iff (reset)
    evt |=> mCount_reg == $past(cfg.masterReload)) else
    $error("master counter not reloaded at event");
  a_start_event: assert property (@(posedge clk_sys) disable iff (reset)
    cfg.start && !running_reg |-> evt) else
    $error("no event on start");
  a_slave_load: assert property (@(posedge clk_sys) disable iff (reset)
    evt && !cfg.stop |=> sCount_reg == $past(cfg.slaveReload)) else
    $error("slave counter not loaded at event");
  a_pin_frozen: assert property (@(posedge clk_sys) disable iff (reset)
    !cfg.outEnable |=> $stable(pin_reg)) else
    $error("pin moved while disabled");
  a_pin_idle: assert property (@(posedge clk_sys) disable iff (reset)
    cfg.outEnable && !started_reg && !cfg.outLevel |=> !pin_reg) else
    $error("pin active before first event");
endmodule
`default_nettype wire

// File: core/pcp_paired_pwm.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcp_paired_pwm #(
  parameter logic [7:0] PRESCALE = pcp_pkg::PRESCALE_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pwmOutputPin
);
  import pcp_pkg::*;

  initial begin
    if (PRESCALE == 8'h00) begin
      $error("PRESCALE must be at least one");
    end
  end

  pcp_cfg_if cfg();

  logic [7:0] div_reg;
  logic tick;
  logic [15:0] mReload_reg;
  logic [15:0] sReload_reg;
  logic oe_reg;
  logic mode_reg;
  logic level_reg;
  logic start_reg;
  logic stop_reg;
  logic evtSeen_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;

  ////////////////////////////////////////////////////////////////
  // Count clock as an enable pulse
  always_ff @(posedge clk_sys) begin
    if (reset || div_reg == PRESCALE - 8'h01) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign tick = (div_reg == PRESCALE - 8'h01);

  ////////////////////////////////////////////////////////////////
  // Write channels taken in either order; response after both
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  assign doWrite = awHeld_reg && wHeld_reg;

  always_ff @(posedge clk_sys) begin
    if (reset || doWrite) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr_reg == ADDR_CTRL ||
        awAddr_reg == ADDR_MRELOAD || awAddr_reg == ADDR_SRELOAD) ?
        RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register stores; start and stop are one-cycle strobes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mReload_reg <= RELOAD_RST;
      sReload_reg <= RELOAD_RST;
      oe_reg <= 1'b0;
      mode_reg <= 1'b0;
      level_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      if (doWrite && awAddr_reg == ADDR_CTRL && wStrb_reg[0]) begin
        start_reg <= wData_reg[CTRL_START];
        stop_reg <= wData_reg[CTRL_STOP];
        oe_reg <= wData_reg[CTRL_OE];
        mode_reg <= wData_reg[CTRL_MODE];
        level_reg <= wData_reg[CTRL_MODE] & wData_reg[CTRL_LEVEL];
      end
      if (doWrite && awAddr_reg == ADDR_MRELOAD) begin
        if (wStrb_reg[0]) mReload_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) mReload_reg[15:8] <= wData_reg[15:8];
      end
      if (doWrite && awAddr_reg == ADDR_SRELOAD) begin
        if (wStrb_reg[0]) sReload_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) sReload_reg[15:8] <= wData_reg[15:8];
      end
    end
  end

  // Sticky period-event flag; set wins over the read that clears it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evtSeen_reg <= 1'b0;
    end else if (cfg.periodEvent) begin
      evtSeen_reg <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready &&
                 s_axi_araddr == ADDR_STATUS) begin
      evtSeen_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read channel, one cycle latency
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: s_axi_rdata <= {27'h000_0000, level_reg, mode_reg,
          oe_reg, 2'b00};
        ADDR_MRELOAD: s_axi_rdata <= {16'h0000, mReload_reg};
        ADDR_SRELOAD: s_axi_rdata <= {16'h0000, sReload_reg};
        ADDR_STATUS: s_axi_rdata <= {29'h0000_0000, evtSeen_reg,
          cfg.pinLevel, cfg.running};
        ADDR_MCOUNT: s_axi_rdata <= {16'h0000, cfg.masterCount};
        ADDR_SCOUNT: s_axi_rdata <= {16'h0000, cfg.slaveCount};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  assign cfg.start = start_reg;
  assign cfg.stop = stop_reg;
  assign cfg.masterReload = mReload_reg;
  assign cfg.slaveReload = sReload_reg;
  assign cfg.outEnable = oe_reg;
  assign cfg.outLevel = level_reg;

  pcp_pair_core u_core (
    .clk_sys(clk_sys),
    .reset(reset),
    .countTick(tick),
    .cfg(cfg)
  );

  assign pwmOutputPin = cfg.pinLevel;

  a_bresp_after: assert property (@(posedge clk_sys) disable iff (reset)
    doWrite |=> s_axi_bvalid) else $error("no write response");
  a_toggle_level: assert property (@(posedge clk_sys) disable iff (reset)
    !mode_reg |-> !level_reg) else $error("level set in toggle mode");
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (reset)
    tick && PRESCALE > 8'h01 |=> !tick) else $error("tick too close");
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcp_pkg::*;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] GO = (ONE << CTRL_START) | (ONE << CTRL_OE);
  localparam logic [31:0] OE_ON = ONE << CTRL_OE;
  localparam logic [31:0] LVL_ONLY = (ONE << CTRL_OE) | (ONE << CTRL_LEVEL);
  localparam logic [31:0] HALT = ONE << CTRL_STOP;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pwmOutputPin;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rd;
  int miscompares = 0;
  int total_checks = 0;
  int highs, rises;
  int caseM[5] = '{9, 9, 9, 9, 4};
  int caseS[5] = '{3, 0, 10, 15, 4};

  pcp_paired_pwm i_dut (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwmOutputPin(pwmOutputPin));

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes are judged at the falling edge, so the rising edge that moves
  // an item is never raced against the design's own updates
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic tkA, tkW, bv;
    bv = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bv) begin
      @(negedge clk_sys);
      tkA = s_axi_awvalid & s_axi_awready;
      tkW = s_axi_wvalid & s_axi_wready;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (tkA) s_axi_awvalid <= 1'b0;
      if (tkW) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic tkA, rv;
    rv = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv) begin
      @(negedge clk_sys);
      tkA = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (tkA) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Counts high cycles and rising edges of the pin over n cycles
  task automatic watchPin(input int n);
    logic prev;
    highs = 0;
    rises = 0;
    @(negedge clk_sys);
    prev = pwmOutputPin;
    repeat (n) begin
      @(negedge clk_sys);
      if (pwmOutputPin === 1'b1) highs++;
      if (pwmOutputPin === 1'b1 && prev === 1'b0) rises++;
      prev = pwmOutputPin;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("data %h, expected %h", got, exp));
  endtask

  task automatic checkResp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("resp %b, expected %b", got, exp));
  endtask

  task automatic checkCount(input int got, input int exp);
    total_checks++;
    if (got != exp) fail($sformatf("pin count %0d, expected %0d", got, exp));
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is a few hundred cycles; this is a generous ceiling
  initial begin
    #200us;
    fail("watchdog expired");
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    // Idle pin and unmapped accesses
    checkCount(int'(pwmOutputPin === 1'b0), 1);
    axiWrite(8'h40, 32'h1234_5678, resp);
    checkResp(resp, RESP_SLVERR);
    axiRead(8'h40, rd, resp);
    checkResp(resp, RESP_SLVERR);
    checkData(rd, 32'h0000_0000);
    // Level bit asked for in toggle mode, not started: pin stays low
    axiWrite(ADDR_CTRL, LVL_ONLY, resp);
    watchPin(20);
    checkCount(highs, 0);
    // Reloads rewritten while running after the first pair; each pair checked over four periods after a 40-cycle settle
    foreach (caseM[i]) begin
      axiWrite(ADDR_MRELOAD, 32'(caseM[i]), resp);
      axiWrite(ADDR_SRELOAD, 32'(caseS[i]), resp);
      if (i == 0) begin
        axiWrite(ADDR_CTRL, GO, resp);
        axiRead(ADDR_STATUS, rd, resp);
        checkData(rd & 32'h0000_0005, 32'h0000_0005);
      end
      repeat (40) @(posedge clk_sys);
      watchPin(4 * (caseM[i] + 1));
      checkCount(highs, 4 * ((caseS[i] < caseM[i] + 1) ?
        caseS[i] : caseM[i] + 1));
      checkCount(rises, (caseS[i] > 0 && caseS[i] < caseM[i] + 1) ?
        4 : 0);
    end
    // Output enable cleared: pin frozen at whatever it held
    axiWrite(ADDR_CTRL, 32'h0000_0000, resp);
    @(negedge clk_sys);
    highs = int'(pwmOutputPin === 1'b1);
    watchPin(25);
    checkCount(highs, (pwmOutputPin === 1'b1) ? 25 : 0);
    checkCount(rises, 0);
    axiWrite(ADDR_CTRL, OE_ON, resp);
    repeat (12) @(posedge clk_sys);
    watchPin(20);
    checkCount(highs, 16);
    axiWrite(ADDR_CTRL, HALT, resp);
    axiRead(ADDR_STATUS, rd, resp);
    checkData(rd & (ONE << STAT_RUN), 32'h0000_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
